// ### logic/port_wake_bank.sv
// Per-port wake event and default VLAN tag registers for ports 1 to 7.
// Assumes a byte-wide management access port with one-cycle strobes,
// event pulses synchronous to i_core_clk, and the global switch MAC address
// supplied from the global register bank.
// Function
// - Each port 1..7 has its own register copy, selected by the address port digit.
// - Tag high byte is read-write: PCP[7:5], DEI[4], VID[11:8]; resets to zero.
// - Tag low byte is read-write VID[7:0], resets to one.
// - Magic packet counts only when destination equals the global switch MAC address.
// - Magic packet sets event bit 2, sticky until software write clears it.
// - Link up sets event bit 1, sticky until software write clears it.
// - Cable energy sets event bit 0, sticky until software write clears it.
// - Link and energy bits and enables work only on integrated PHY ports.
// - Magic enable bit 2 lets magic detection drive the power event pin.
// - Link enable bit 1 lets link-up detection drive the power event pin.
// - Energy enable bit 0 lets energy detection drive the power event pin.
`include "port_wake_cfg.svh"

module port_wake_bank #(
    parameter int NUM_PORTS = 7,
    parameter logic [6:0] PHY_PORT_MASK = `PWK_PHY_PORT_MASK
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // Management register access
    input wire port_wake_pkg::reg_addr_type i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire port_wake_pkg::reg_byte_type i_reg_wdata,
    output port_wake_pkg::reg_byte_type o_reg_rdata,
    output logic o_reg_rvalid,
    // Global switch MAC address
    input wire port_wake_pkg::mac_addr_type i_switch_mac,
    // Magic packet candidate from the receive path
    input wire logic i_magic_valid,
    input wire logic [2:0] i_magic_port,
    input wire port_wake_pkg::mac_addr_type i_magic_dest,
    // Per-port link and energy event pulses, bit 0 is port 1
    input wire logic [6:0] i_link_up_evt,
    input wire logic [6:0] i_energy_evt,
    // Outputs
    output port_wake_pkg::vlan_tag_type o_default_tag [NUM_PORTS],
    output logic o_power_event_pin
);

    // Address hits a valid port page with nothing in the gap digits
    function automatic logic page_hit(input port_wake_pkg::reg_addr_type addr, input int port);
        logic [3:0] digit;
        digit = addr[`PWK_ADDR_PORT_MSB:`PWK_ADDR_PORT_LSB];
        page_hit = (digit == 4'(port)) && (addr[11:8] == `PWK_ADDR_GAP);
    endfunction : page_hit

    port_wake_pkg::reg_byte_type slice_rdata [NUM_PORTS];
    logic [NUM_PORTS-1:0] slice_wake;
    logic [NUM_PORTS-1:0] slice_sel;
    logic [NUM_PORTS-1:0] magic_hit;
    logic mac_match;
    port_wake_pkg::reg_byte_type rdata_r;
    port_wake_pkg::reg_byte_type rdata_nxt;
    logic rvalid_r;
    logic rvalid_nxt;
    logic pin_r;
    logic pin_nxt;

    // Frames to any other address are ignored, even if well formed
    assign mac_match = i_magic_valid && (i_magic_dest == i_switch_mac);

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        assign slice_sel[p] = page_hit(i_reg_addr, p + 1);
        assign magic_hit[p] = mac_match && (i_magic_port == 3'(p + 1));

        port_wake_slice #(
            .HAS_PHY(PHY_PORT_MASK[p])
        ) u_slice (
            .i_core_clk(i_core_clk),
            .i_reset_n(i_reset_n),
            .i_wr(i_reg_wr && slice_sel[p]),
            .i_offset(i_reg_addr[`PWK_ADDR_OFS_MSB:`PWK_ADDR_OFS_LSB]),
            .i_wdata(i_reg_wdata),
            .o_rdata(slice_rdata[p]),
            .i_magic_evt(magic_hit[p]),
            .i_link_evt(i_link_up_evt[p]),
            .i_energy_evt(i_energy_evt[p]),
            .o_default_tag(o_default_tag[p]),
            .o_wake_req(slice_wake[p])
        );
    end

    always_comb begin
        rdata_nxt = rdata_r;
        rvalid_nxt = i_reg_rd;
        if (i_reg_rd) begin
            rdata_nxt = 8'h00;
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (slice_sel[p]) begin
                    rdata_nxt = slice_rdata[p];
                end
            end
        end
        // Level follows the enabled flags, so clearing the last enabled one drops the pin
        pin_nxt = |slice_wake;
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
            pin_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            pin_r <= pin_nxt;
        end
    end

    assign o_reg_rdata = rdata_r;
    assign o_reg_rvalid = rvalid_r;
    assign o_power_event_pin = pin_r;

endmodule : port_wake_bank

// ### logic/port_wake_cfg.svh
// Constants for the per-port wake event and default tag register bank.
// Assumes byte-wide registers with a 16-bit address of the form 0xN0oo.
`ifndef PORT_WAKE_CFG_SVH
`define PORT_WAKE_CFG_SVH

// Register offsets inside one port's page
`define PWK_OFS_TAG_HIGH 8'h00
`define PWK_OFS_TAG_LOW 8'h01
`define PWK_OFS_EVT_FLAGS 8'h13
`define PWK_OFS_EVT_ENABLES 8'h17

// Address layout: port number digit and page offset
`define PWK_ADDR_PORT_MSB 15
`define PWK_ADDR_PORT_LSB 12
`define PWK_ADDR_OFS_MSB 7
`define PWK_ADDR_OFS_LSB 0
`define PWK_ADDR_GAP 4'h0

// Valid port numbers
`define PWK_PORT_FIRST 4'h1
`define PWK_PORT_LAST 4'h7

// Reset values
`define PWK_RST_TAG_HIGH 8'h00
`define PWK_RST_TAG_LOW 8'h01
`define PWK_RST_EVT 3'h0

// Event bit positions
`define PWK_BIT_MAGIC 2
`define PWK_BIT_LINK 1
`define PWK_BIT_ENERGY 0

// Default-tag high byte fields
`define PWK_TAG_PCP_MSB 7
`define PWK_TAG_PCP_LSB 5
`define PWK_TAG_DEI 4
`define PWK_TAG_VID_HI_MSB 3
`define PWK_TAG_VID_HI_LSB 0

// Ports 1 to 5 carry an integrated PHY, ports 6 and 7 are external MACs
`define PWK_PHY_PORT_MASK 7'h1F

`endif

// ### logic/port_wake_pkg.sv
// Types shared by the wake event and default tag register bank.
// Assumes the constants of port_wake_cfg.svh.
package port_wake_pkg;

    typedef logic [7:0] reg_byte_type;
    typedef logic [15:0] reg_addr_type;
    typedef logic [2:0] wake_bits_type;
    typedef logic [15:0] vlan_tag_type;
    typedef logic [47:0] mac_addr_type;

endpackage : port_wake_pkg

// ### logic/port_wake_slice.sv
// One port's copy of the default tag, wake event flags and wake enables.
// Assumes the parent decodes the port number and gives a one-cycle write strobe.
`include "port_wake_cfg.svh"

module port_wake_slice #(
    parameter bit HAS_PHY = 1'b1
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // Register access
    input wire logic i_wr,
    input wire logic [7:0] i_offset,
    input wire port_wake_pkg::reg_byte_type i_wdata,
    output port_wake_pkg::reg_byte_type o_rdata,
    // Detected events, one-cycle pulses
    input wire logic i_magic_evt,
    input wire logic i_link_evt,
    input wire logic i_energy_evt,
    // Results
    output port_wake_pkg::vlan_tag_type o_default_tag,
    output logic o_wake_req
);

    port_wake_pkg::reg_byte_type tag_high_r;
    port_wake_pkg::reg_byte_type tag_high_nxt;
    port_wake_pkg::reg_byte_type tag_low_r;
    port_wake_pkg::reg_byte_type tag_low_nxt;
    port_wake_pkg::wake_bits_type flags_r;
    port_wake_pkg::wake_bits_type flags_nxt;
    port_wake_pkg::wake_bits_type enables_r;
    port_wake_pkg::wake_bits_type enables_nxt;
    port_wake_pkg::wake_bits_type set_vec;
    port_wake_pkg::wake_bits_type clr_vec;
    port_wake_pkg::wake_bits_type phy_only;

    // External MAC ports have no link or energy sense at all
    assign phy_only = HAS_PHY ? 3'h7 : 3'h4;

    always_comb begin
        tag_high_nxt = tag_high_r;
        tag_low_nxt = tag_low_r;
        enables_nxt = enables_r;
        set_vec = 3'h0;
        clr_vec = 3'h0;
        set_vec[`PWK_BIT_MAGIC] = i_magic_evt;
        set_vec[`PWK_BIT_LINK] = i_link_evt;
        set_vec[`PWK_BIT_ENERGY] = i_energy_evt;
        if (i_wr && i_offset == `PWK_OFS_TAG_HIGH) begin
            tag_high_nxt = i_wdata;
        end else if (i_wr && i_offset == `PWK_OFS_TAG_LOW) begin
            tag_low_nxt = i_wdata;
        end else if (i_wr && i_offset == `PWK_OFS_EVT_FLAGS) begin
            clr_vec = i_wdata[2:0];
        end else if (i_wr && i_offset == `PWK_OFS_EVT_ENABLES) begin
            enables_nxt = i_wdata[2:0] & phy_only;
        end
        // A new event in the clearing cycle survives the clear
        flags_nxt = ((flags_r & ~clr_vec) | set_vec) & phy_only;
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tag_high_r <= `PWK_RST_TAG_HIGH;
            tag_low_r <= `PWK_RST_TAG_LOW;
            flags_r <= `PWK_RST_EVT;
            enables_r <= `PWK_RST_EVT;
        end else begin
            tag_high_r <= tag_high_nxt;
            tag_low_r <= tag_low_nxt;
            flags_r <= flags_nxt;
            enables_r <= enables_nxt;
        end
    end

    always_comb begin
        if (i_offset == `PWK_OFS_TAG_HIGH) begin
            o_rdata = tag_high_r;
        end else if (i_offset == `PWK_OFS_TAG_LOW) begin
            o_rdata = tag_low_r;
        end else if (i_offset == `PWK_OFS_EVT_FLAGS) begin
            o_rdata = {5'h00, flags_r};
        end else if (i_offset == `PWK_OFS_EVT_ENABLES) begin
            o_rdata = {5'h00, enables_r};
        end else begin
            o_rdata = 8'h00;
        end
    end

    assign o_default_tag = {tag_high_r, tag_low_r};
    // Each event asks for wake only through its own enable
    assign o_wake_req = |(flags_r & enables_r);

endmodule : port_wake_slice

// ### verif/port_wake_bank_assertions.sv
// Checker of register answers and power event pin timing of port_wake_bank.
// Assumes inputs change away from the rising clock edge.
module port_wake_bank_assertions (
    // Watched ports
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire port_wake_pkg::reg_addr_type i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire port_wake_pkg::reg_byte_type i_reg_wdata,
    input wire port_wake_pkg::reg_byte_type o_reg_rdata,
    input wire logic o_reg_rvalid,
    input wire logic i_magic_valid,
    input wire logic [6:0] i_link_up_evt,
    input wire logic [6:0] i_energy_evt,
    input wire logic o_power_event_pin
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_reset_n);
    property p_rvalid; o_reg_rvalid == $past(i_reg_rd); endproperty
    a_rvalid: assert property (p_rvalid) else $error("read answer timing");
    property p_hold; !i_reg_rd |=> $stable(o_reg_rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_gap; i_reg_rd && i_reg_addr[11:8] != 4'h0 |=> o_reg_rdata == 8'h00; endproperty
    a_gap: assert property (p_gap) else $error("unmapped read not zero");
    property p_top; i_reg_rd && i_reg_addr[7:0] == 8'h13 |=> o_reg_rdata[7:3] == 5'h00; endproperty
    a_top: assert property (p_top) else $error("reserved flag bits set");
    property p_mac; i_reg_rd && i_reg_addr[15:13] == 3'h3 && i_reg_addr[11:0] == 12'h013
        |=> o_reg_rdata[1:0] == 2'h0; endproperty
    a_mac: assert property (p_mac) else $error("link or energy flag on MAC port");
    property p_tag; i_reg_wr && i_reg_addr == 16'h1000 ##2 i_reg_rd && i_reg_addr == 16'h1000
        |=> o_reg_rdata == $past(i_reg_wdata, 3); endproperty
    a_tag: assert property (p_tag) else $error("tag byte not read back");
    property p_rise; $rose(o_power_event_pin)
        |-> $past(i_magic_valid || i_link_up_evt != 7'h00 || i_energy_evt != 7'h00 || i_reg_wr, 2); endproperty
    a_rise: assert property (p_rise) else $error("pin rose without cause");
    property p_fall; $fell(o_power_event_pin) |-> $past(i_reg_wr, 2); endproperty
    a_fall: assert property (p_fall) else $error("pin fell without write");
    c_pin: cover property ($rose(o_power_event_pin));
    c_magic: cover property (i_magic_valid);
    c_gap: cover property (i_reg_rd && i_reg_addr[11:8] != 4'h0);
endmodule : port_wake_bank_assertions
bind port_wake_bank port_wake_bank_assertions u_chk (.*);

// ### verif/port_wake_bank_bench.sv
// Self-checking bench of port_wake_bank through its byte register port.
// Assumes the bound checker and wake_monitor watching the pin.
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; $display("unexpected %0t %h %h", $time, a, b); end end
module port_wake_bank_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam port_wake_pkg::mac_addr_type MAC = 48'h02AB_CDEF_0123;
    localparam logic [15:0] BAD [4] = '{16'h0000, 16'h8000, 16'h1100, 16'h1002};
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, mv = 1'b0, pin, rv;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wd = 8'h00, rdat;
    logic [2:0] mp = 3'h0;
    logic [47:0] md = 48'h0000_0000_0000;
    logic [6:0] lk = 7'h00, en = 7'h00;
    port_wake_pkg::vlan_tag_type tags [7];
    int wakes, err_count = 0, n_checks = 0;
    port_wake_bank dut (.i_core_clk(clk), .i_reset_n(rst_n), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_wdata(wd), .o_reg_rdata(rdat), .o_reg_rvalid(rv), .i_switch_mac(MAC), .i_magic_valid(mv),
        .i_magic_port(mp), .i_magic_dest(md), .i_link_up_evt(lk), .i_energy_evt(en), .o_default_tag(tags),
        .o_power_event_pin(pin));
    wake_monitor u_pm (.i_core_clk(clk), .i_reset_n(rst_n), .i_pin(pin), .o_wakes(wakes));
    initial forever #12.5 clk = ~clk;
    task automatic w(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk) {addr, wd, wr} = {a, d, 1'b1};
        @(negedge clk) wr = 1'b0;
    endtask : w
    task automatic r(input logic [15:0] a, input logic [7:0] e);
        @(negedge clk) {addr, rd} = {a, 1'b1};
        @(negedge clk) rd = 1'b0;
        `CHK(rv, 1'b1)
        `CHK(rdat, e)
    endtask : r
    task automatic ev(input logic [2:0] p, input logic [47:0] d, input logic [6:0] l, input logic [6:0] e);
        @(negedge clk) {mv, mp, md, lk, en} = {p != 3'h0, p, d, l, e};
        @(negedge clk) {mv, lk, en} = 15'h0000;
    endtask : ev
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        for (int p = 1; p <= 7; p++) begin
            r({p[3:0], 12'h000}, 8'h00);
            r({p[3:0], 12'h001}, 8'h01);
            r({p[3:0], 12'h013}, 8'h00);
            r({p[3:0], 12'h017}, 8'h00);
            w({p[3:0], 12'h000}, 8'hA0 | 8'(p));
            w({p[3:0], 12'h001}, 8'(p * 16 + 3));
        end
        foreach (BAD[i]) begin
            w(BAD[i], 8'hFF);
            r(BAD[i], 8'h00);
        end
        for (int p = 1; p <= 7; p++) begin
            r({p[3:0], 12'h001}, 8'(p * 16 + 3));
            `CHK(tags[p - 1], {8'hA0 | 8'(p), 8'(p * 16 + 3)})
        end
        w(16'h1000, 8'h5C);
        r(16'h1000, 8'h5C);
        $display("test tags done");
        w(16'h3017, 8'h04);
        ev(3'h3, ~MAC, 7'h00, 7'h00);
        r(16'h3013, 8'h00);
        ev(3'h3, MAC, 7'h00, 7'h00);
        r(16'h3013, 8'h04);
        `CHK(pin, 1'b1)
        w(16'h3013, 8'h04);
        r(16'h3013, 8'h00);
        `CHK(pin, 1'b0)
        `CHK(wakes, 1)
        // Magic flag without its enable must leave the pin alone
        ev(3'h1, MAC, 7'h00, 7'h00);
        r(16'h1013, 8'h04);
        `CHK(pin, 1'b0)
        w(16'h1013, 8'h04);
        r(16'h1013, 8'h00);
        $display("test magic done");
        ev(3'h0, MAC, 7'h02, 7'h00);
        r(16'h2013, 8'h02);
        ev(3'h0, MAC, 7'h00, 7'h02);
        r(16'h2013, 8'h03);
        `CHK(pin, 1'b0)
        w(16'h2017, 8'h01);
        r(16'h2017, 8'h01);
        `CHK(pin, 1'b1)
        w(16'h2013, 8'h01);
        r(16'h2013, 8'h02);
        `CHK(pin, 1'b0)
        w(16'h4017, 8'h02);
        ev(3'h0, MAC, 7'h08, 7'h00);
        r(16'h4013, 8'h02);
        `CHK(pin, 1'b1)
        w(16'h4013, 8'hFF);
        ev(3'h0, MAC, 7'h60, 7'h60);
        w(16'h6017, 8'h07);
        r(16'h6013, 8'h00);
        r(16'h6017, 8'h04);
        `CHK(pin, 1'b0)
        // Magic still counts on an external MAC port
        ev(3'h6, MAC, 7'h00, 7'h00);
        r(16'h6013, 8'h04);
        `CHK(pin, 1'b1)
        w(16'h6013, 8'h04);
        r(16'h6013, 8'h00);
        `CHK(pin, 1'b0)
        // Link event in the same cycle as its clearing write survives
        ev(3'h0, MAC, 7'h10, 7'h00);
        fork
            w(16'h5013, 8'h02);
            ev(3'h0, MAC, 7'h10, 7'h00);
        join
        r(16'h5013, 8'h02);
        w(16'h5013, 8'h02);
        r(16'h5013, 8'h00);
        `CHK(wakes, 4)
        $display("test link and energy done");
        @(negedge clk) rst_n = 1'b0;
        @(negedge clk) rst_n = 1'b1;
        r(16'h1000, 8'h00);
        r(16'h1001, 8'h01);
        r(16'h6017, 8'h00);
        `CHK(tags[0], 16'h0001)
        `CHK(pin, 1'b0)
        $display("test reset done");
        summarize();
    end
    initial begin
        #100us;
        err_count++;
        summarize();
    end
endmodule : port_wake_bank_bench

// ### verif/wake_monitor.sv
// Power manager model counting wake requests seen on the power event pin.
// Assumes an active high level synchronous to i_core_clk.
module wake_monitor (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // Watched pin and result
    input wire logic i_pin,
    output int o_wakes
);
    timeunit 1ns;
    timeprecision 1ps;
    int wakes_r;
    int wakes_nxt;
    logic last_r;
    assign o_wakes = wakes_r;
    always_comb begin
        wakes_nxt = wakes_r + ((i_pin && !last_r) ? 1 : 0);
    end
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wakes_r <= 0;
            last_r <= 1'b0;
        end else begin
            wakes_r <= wakes_nxt;
            last_r <= i_pin;
        end
    end
endmodule : wake_monitor
